// file: design/occ_defs.vh
// Register map, field positions and reset values for the output channel config block
`ifndef OCC_DEFS_VH
`define OCC_DEFS_VH

// Register indices; the byte address is four times the index
`define OCC_IDX_DRV23     4'd7
`define OCC_IDX_DIV23     4'd8
`define OCC_IDX_CFG4      4'd9
`define OCC_IDX_FRAC4_HI  4'd10
`define OCC_IDX_FRAC4_LO  4'd11
`define OCC_IDX_STATUS    4'd12

// Driver register fields
`define OCC_CH3_DRV_HI    8
`define OCC_CH3_DRV_LO    7
`define OCC_CH3_EN_HI     6
`define OCC_CH3_EN_LO     5
`define OCC_CH2_DRV_HI    4
`define OCC_CH2_DRV_LO    3
`define OCC_CH2_EN_HI     2
`define OCC_CH2_EN_LO     1
`define OCC_SUPPLY_BIT    0

// Shared divider field
`define OCC_DIV_HI        7
`define OCC_DIV_LO        0

// Channel 4 config fields
`define OCC_MUX_HI        14
`define OCC_MUX_LO        13
`define OCC_PRE_HI        12
`define OCC_PRE_LO        10
`define OCC_FRAC_EN_BIT   9
`define OCC_SLEW_BIT      8
`define OCC_NEG_EN_BIT    7
`define OCC_POS_EN_BIT    6

// Writable bit masks; reserved bits are stored as zero
`define OCC_MASK_DRV23    16'h01ff
`define OCC_MASK_DIV23    16'h00ff
`define OCC_MASK_CFG4     16'h7fdf
`define OCC_MASK_FRAC4_HI 16'h0fff
`define OCC_MASK_FRAC4_LO 16'hffff

// Reset values
`define OCC_RST_REG       16'h0000

// Enable modes
`define OCC_EN_OFF        2'b00
`define OCC_EN_CLOCK      2'b01
`define OCC_EN_LOW        2'b10
`define OCC_EN_HIGH       2'b11

// Driver kinds, decoded
`define OCC_DRV_LVDS      2'd0
`define OCC_DRV_CML       2'd1
`define OCC_DRV_PECL      2'd2
`define OCC_DRV_LVCMOS    2'd1
`define OCC_DRV_HCSL      2'd2

// Source select, decoded
`define OCC_SRC_PLL       2'd0
`define OCC_SRC_PRI       2'd1
`define OCC_SRC_SEC       2'd2

// Pre-divider codes and ratios
`define OCC_PRE_CODE_2    3'b000
`define OCC_PRE_CODE_3    3'b001
`define OCC_PRE_CODE_1    3'b111
`define OCC_PRE_RATIO_1   2'd1
`define OCC_PRE_RATIO_2   2'd2
`define OCC_PRE_RATIO_3   2'd3

`endif

// file: design/occ_chan_decode.v
// Decoder for one differential channel: driver kind and enable mode
`timescale 1ns/100ps
module occ_chan_decode (
   input  wire [1:0] i_drv_code,
   input  wire [1:0] i_en_code,
   input  wire       i_alt_kind,
   output reg  [1:0] o_drv_kind,
   output reg        o_active,
   output reg        o_static,
   output reg        o_static_level
);
`include "occ_defs.vh"

   // Codes 00 and 01 both mean LVDS; alt kind picks LVCMOS/HCSL for channel 4
   always @* begin
      case (i_drv_code)
         2'b10:   o_drv_kind = i_alt_kind ? `OCC_DRV_LVCMOS : `OCC_DRV_CML;
         2'b11:   o_drv_kind = i_alt_kind ? `OCC_DRV_HCSL : `OCC_DRV_PECL;
         default: o_drv_kind = `OCC_DRV_LVDS;
      endcase
   end

   // Enable mode: off, clocking, static low, static high
   always @* begin
      o_active       = (i_en_code == `OCC_EN_CLOCK);
      o_static       = i_en_code[1];
      o_static_level = (i_en_code == `OCC_EN_HIGH);
   end
endmodule

// file: design/occ_output_config.v
// Output channel 2 to 4 configuration registers with an AHB-Lite slave
`timescale 1ns/100ps
module occ_output_config #(
   parameter DIV_W  = 8,
   parameter FRAC_W = 20
) (
   input  wire              i_core_clk,
   input  wire              i_reset_n,
   input  wire              i_hsel,
   input  wire [31:0]       i_haddr,
   input  wire [1:0]        i_htrans,
   input  wire              i_hwrite,
   input  wire [2:0]        i_hsize,
   input  wire [31:0]       i_hwdata,
   input  wire              i_hready,
   output reg  [31:0]       o_hrdata,
   output reg               o_hreadyout,
   output reg               o_hresp,
   output reg  [1:0]        o_ch2_driver_type,
   output reg               o_ch2_active,
   output reg               o_ch2_static,
   output reg               o_ch2_static_level,
   output reg  [1:0]        o_ch3_driver_type,
   output reg               o_ch3_active,
   output reg               o_ch3_static,
   output reg               o_ch3_static_level,
   output reg               o_ch2_ch3_supply_level,
   output reg  [DIV_W:0]    o_ch2_ch3_divide_ratio,
   output reg  [1:0]        o_ch4_source_select,
   output reg  [1:0]        o_ch4_prescale_ratio,
   output reg               o_ch4_prescale_bypass,
   output reg               o_ch4_fractional_enable,
   output reg               o_ch4_single_ended_slew,
   output reg               o_ch4_positive_side_enable,
   output reg               o_ch4_negative_side_enable,
   output reg  [1:0]        o_ch4_driver_type,
   output reg               o_ch4_active,
   output reg               o_ch4_static,
   output reg               o_ch4_static_level,
   output reg               o_ch4_supply_level,
   output reg  [FRAC_W-1:0] o_ch4_fraction_word
);
`include "occ_defs.vh"

   // Stored registers
   reg  [15:0]       drv23_q;
   reg  [15:0]       div23_q;
   reg  [15:0]       cfg4_q;
   reg  [15:0]       frac_hi_q;
   reg  [15:0]       frac_lo_q;

   // Captured address phase, and channel 4 status flags
   reg               wr_pend_q;
   reg  [3:0]        wr_idx_q;
   reg               prescale_bad_q;
   reg               neg_refused_q;

   wire              addr_take;
   wire [3:0]        addr_idx;
   wire              addr_ok;
   wire [15:0]       wdata;

   // Decoded channel fields, read data and write forwarding
   wire [1:0]        ch2_kind;
   wire              ch2_act;
   wire              ch2_st;
   wire              ch2_lvl;
   wire [1:0]        ch3_kind;
   wire              ch3_act;
   wire              ch3_st;
   wire              ch3_lvl;
   wire [1:0]        ch4_kind;
   wire              ch4_act;
   wire              ch4_st;
   wire              ch4_lvl;
   reg  [1:0]        pre_ratio;
   reg  [1:0]        src_sel;
   reg  [31:0]       rd_word;
   reg  [15:0]       cfg4_wr;
   reg  [15:0]       fwd_word;
   reg               fwd_hit;

   // A transfer is taken on a valid NONSEQ/SEQ address phase
   assign addr_take = i_hsel & i_hready & i_htrans[1];
   assign addr_idx  = i_haddr[5:2];
   assign addr_ok   = (i_haddr[31:6] == 26'h0000000) & (i_haddr[1:0] == 2'b00);
   assign wdata     = i_hwdata[15:0];

   // Per-channel decoders
   occ_chan_decode u_dec_ch2 (
      .i_drv_code     (drv23_q[`OCC_CH2_DRV_HI:`OCC_CH2_DRV_LO]),
      .i_en_code      (drv23_q[`OCC_CH2_EN_HI:`OCC_CH2_EN_LO]),
      .i_alt_kind     (1'b0),
      .o_drv_kind     (ch2_kind),
      .o_active       (ch2_act),
      .o_static       (ch2_st),
      .o_static_level (ch2_lvl)
   );

   occ_chan_decode u_dec_ch3 (
      .i_drv_code     (drv23_q[`OCC_CH3_DRV_HI:`OCC_CH3_DRV_LO]),
      .i_en_code      (drv23_q[`OCC_CH3_EN_HI:`OCC_CH3_EN_LO]),
      .i_alt_kind     (1'b0),
      .o_drv_kind     (ch3_kind),
      .o_active       (ch3_act),
      .o_static       (ch3_st),
      .o_static_level (ch3_lvl)
   );

   occ_chan_decode u_dec_ch4 (
      .i_drv_code     (cfg4_q[`OCC_CH2_DRV_HI:`OCC_CH2_DRV_LO]),
      .i_en_code      (cfg4_q[`OCC_CH2_EN_HI:`OCC_CH2_EN_LO]),
      .i_alt_kind     (1'b1),
      .o_drv_kind     (ch4_kind),
      .o_active       (ch4_act),
      .o_static       (ch4_st),
      .o_static_level (ch4_lvl)
   );

   // Pre-divider ratio; reserved codes fall back to divide by 1
   always @* begin
      case (cfg4_q[`OCC_PRE_HI:`OCC_PRE_LO])
         `OCC_PRE_CODE_2: pre_ratio = `OCC_PRE_RATIO_2;
         `OCC_PRE_CODE_3: pre_ratio = `OCC_PRE_RATIO_3;
         default:         pre_ratio = `OCC_PRE_RATIO_1;
      endcase
   end

   // Source mux: 00 and 11 both route the PLL
   always @* begin
      case (cfg4_q[`OCC_MUX_HI:`OCC_MUX_LO])
         2'b01:   src_sel = `OCC_SRC_PRI;
         2'b10:   src_sel = `OCC_SRC_SEC;
         default: src_sel = `OCC_SRC_PLL;
      endcase
   end

   // Negative side write is forced off unless positive side is also set
   always @* begin
      cfg4_wr = wdata & `OCC_MASK_CFG4;
      if (!wdata[`OCC_POS_EN_BIT]) begin
         cfg4_wr[`OCC_NEG_EN_BIT] = 1'b0;
      end
   end

   // Read mux; unmapped indices read zero
   always @* begin
      rd_word = 32'h00000000;
      case (addr_idx)
         `OCC_IDX_DRV23:    rd_word[15:0] = drv23_q;
         `OCC_IDX_DIV23:    rd_word[15:0] = div23_q;
         `OCC_IDX_CFG4:     rd_word[15:0] = cfg4_q;
         `OCC_IDX_FRAC4_HI: rd_word[15:0] = frac_hi_q;
         `OCC_IDX_FRAC4_LO: rd_word[15:0] = frac_lo_q;
         `OCC_IDX_STATUS:   rd_word[1:0]  = {neg_refused_q, prescale_bad_q};
         default:           rd_word = 32'h00000000;
      endcase
      if (!addr_ok) begin
         rd_word = 32'h00000000;
      end
   end

   // A read taken during a write's data phase would fetch the old word, so
   // the write data in flight is forwarded; status reads still lag one write
   always @* begin
      fwd_hit = wr_pend_q & (wr_idx_q == addr_idx);
      case (wr_idx_q)
         `OCC_IDX_DRV23:    fwd_word = wdata & `OCC_MASK_DRV23;
         `OCC_IDX_DIV23:    fwd_word = wdata & `OCC_MASK_DIV23;
         `OCC_IDX_CFG4:     fwd_word = cfg4_wr;
         `OCC_IDX_FRAC4_HI: fwd_word = wdata & `OCC_MASK_FRAC4_HI;
         `OCC_IDX_FRAC4_LO: fwd_word = wdata & `OCC_MASK_FRAC4_LO;
         default: begin
            fwd_word = 16'h0000;
            fwd_hit  = 1'b0;
         end
      endcase
   end

   // Bus slave: zero wait states, always OKAY; read data lands in data phase
   always @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         wr_pend_q   <= 1'b0;
         wr_idx_q    <= 4'h0;
         o_hrdata    <= 32'h00000000;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end else begin
         wr_pend_q <= addr_take & i_hwrite & addr_ok;
         if (addr_take) begin
            wr_idx_q <= addr_idx;
         end
         if (addr_take & ~i_hwrite) begin
            o_hrdata <= (fwd_hit & addr_ok) ? {16'h0000, fwd_word} : rd_word;
         end
      end
   end

   // Register writes in the data phase; supply bits reset to zero
   always @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         drv23_q        <= `OCC_RST_REG;
         div23_q        <= `OCC_RST_REG;
         cfg4_q         <= `OCC_RST_REG;
         frac_hi_q      <= `OCC_RST_REG;
         frac_lo_q      <= `OCC_RST_REG;
         prescale_bad_q <= 1'b0;
         neg_refused_q  <= 1'b0;
      end else if (wr_pend_q) begin
         case (wr_idx_q)
            `OCC_IDX_DRV23:    drv23_q   <= wdata & `OCC_MASK_DRV23;
            `OCC_IDX_DIV23:    div23_q   <= wdata & `OCC_MASK_DIV23;
            `OCC_IDX_CFG4: begin
               cfg4_q <= cfg4_wr;
               // Sticky-free status: reflects the latest write
               neg_refused_q  <= wdata[`OCC_NEG_EN_BIT] & ~wdata[`OCC_POS_EN_BIT];
               prescale_bad_q <= (wdata[`OCC_PRE_HI:`OCC_PRE_LO] != `OCC_PRE_CODE_2) &
                                 (wdata[`OCC_PRE_HI:`OCC_PRE_LO] != `OCC_PRE_CODE_3) &
                                 (wdata[`OCC_PRE_HI:`OCC_PRE_LO] != `OCC_PRE_CODE_1);
            end
            `OCC_IDX_FRAC4_HI: frac_hi_q <= wdata & `OCC_MASK_FRAC4_HI;
            `OCC_IDX_FRAC4_LO: frac_lo_q <= wdata & `OCC_MASK_FRAC4_LO;
            default: begin
            end
         endcase
      end
   end

   // Decoded settings to the analog side, all registered
   always @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_ch2_driver_type          <= 2'd0;
         o_ch2_active               <= 1'b0;
         o_ch2_static               <= 1'b0;
         o_ch2_static_level         <= 1'b0;
         o_ch3_driver_type          <= 2'd0;
         o_ch3_active               <= 1'b0;
         o_ch3_static               <= 1'b0;
         o_ch3_static_level         <= 1'b0;
         o_ch2_ch3_supply_level     <= 1'b0;
         o_ch2_ch3_divide_ratio     <= {{DIV_W{1'b0}}, 1'b1};
         o_ch4_source_select        <= 2'd0;
         o_ch4_prescale_ratio       <= `OCC_PRE_RATIO_1;
         o_ch4_prescale_bypass      <= 1'b1;
         o_ch4_fractional_enable    <= 1'b0;
         o_ch4_single_ended_slew    <= 1'b0;
         o_ch4_positive_side_enable <= 1'b0;
         o_ch4_negative_side_enable <= 1'b0;
         o_ch4_driver_type          <= 2'd0;
         o_ch4_active               <= 1'b0;
         o_ch4_static               <= 1'b0;
         o_ch4_static_level         <= 1'b0;
         o_ch4_supply_level         <= 1'b0;
         o_ch4_fraction_word        <= {FRAC_W{1'b0}};
      end else begin
         o_ch2_driver_type          <= ch2_kind;
         o_ch2_active               <= ch2_act;
         o_ch2_static               <= ch2_st;
         o_ch2_static_level         <= ch2_lvl;
         o_ch3_driver_type          <= ch3_kind;
         o_ch3_active               <= ch3_act;
         o_ch3_static               <= ch3_st;
         o_ch3_static_level         <= ch3_lvl;
         o_ch2_ch3_supply_level     <= drv23_q[`OCC_SUPPLY_BIT];
         // One ratio feeds both channels so they match in frequency whenever both are clocking
         o_ch2_ch3_divide_ratio     <= {1'b0, div23_q[DIV_W-1:0]} + 1'b1;
         o_ch4_source_select        <= src_sel;
         // Fraction disabled: pre-divider bypassed, ratio reads as 1
         o_ch4_prescale_bypass      <= ~cfg4_q[`OCC_FRAC_EN_BIT];
         o_ch4_prescale_ratio       <= cfg4_q[`OCC_FRAC_EN_BIT] ? pre_ratio
                                       : `OCC_PRE_RATIO_1;
         o_ch4_fractional_enable    <= cfg4_q[`OCC_FRAC_EN_BIT];
         o_ch4_single_ended_slew    <= cfg4_q[`OCC_SLEW_BIT];
         o_ch4_positive_side_enable <= cfg4_q[`OCC_POS_EN_BIT];
         o_ch4_negative_side_enable <= cfg4_q[`OCC_NEG_EN_BIT] &
                                       cfg4_q[`OCC_POS_EN_BIT];
         o_ch4_driver_type          <= ch4_kind;
         o_ch4_active               <= ch4_act;
         o_ch4_static               <= ch4_st;
         o_ch4_static_level         <= ch4_lvl;
         o_ch4_supply_level         <= cfg4_q[`OCC_SUPPLY_BIT];
         o_ch4_fraction_word        <= {frac_hi_q[3:0], frac_lo_q};
      end
   end
endmodule

// file: verif/occ_output_config_monitor.sv
// Checker for the output channel config block, bound to its top module
`timescale 1ns/100ps
module occ_output_config_chk #(
   parameter DIV_W  = 8,
   parameter FRAC_W = 20
) (
   input wire              i_core_clk,
   input wire              i_reset_n,
   input wire              i_hsel,
   input wire [31:0]       i_haddr,
   input wire [1:0]        i_htrans,
   input wire              i_hwrite,
   input wire [31:0]       i_hwdata,
   input wire              i_hready,
   input wire [31:0]       o_hrdata,
   input wire              o_hreadyout,
   input wire              o_hresp,
   input wire              o_ch2_active,
   input wire              o_ch2_static,
   input wire              o_ch2_static_level,
   input wire [1:0]        o_ch3_driver_type,
   input wire [DIV_W:0]    o_ch2_ch3_divide_ratio,
   input wire [1:0]        o_ch4_source_select,
   input wire [1:0]        o_ch4_prescale_ratio,
   input wire              o_ch4_prescale_bypass,
   input wire              o_ch4_fractional_enable,
   input wire              o_ch4_single_ended_slew,
   input wire              o_ch4_positive_side_enable,
   input wire              o_ch4_negative_side_enable,
   input wire [FRAC_W-1:0] o_ch4_fraction_word
);
   reg        wr_q;
   reg        rd_q;
   reg [31:0] addr_q;
   // Remember the address phase so the data phase knows its target
   always @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= 32'h0;
      end else if (i_hready) begin
         wr_q <= i_hsel & i_htrans[1] & i_hwrite;
         rd_q <= i_hsel & i_htrans[1] & ~i_hwrite;
         addr_q <= i_haddr;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   // Register loads at the end of the data phase; outputs show it one edge later
   property p_bus_ok; o_hreadyout && !o_hresp; endproperty
   a_bus_ok: assert property (p_bus_ok) else $error("bus stalled or errored");
   property p_div; wr_q && addr_q == 32'h20 |-> ##2
      o_ch2_ch3_divide_ratio == {1'b0, $past(i_hwdata[7:0], 2)} + 9'd1; endproperty
   a_div: assert property (p_div) else $error("divide ratio not field plus one");
   property p_ch2_en; wr_q && addr_q == 32'h1c |-> ##2 o_ch2_active == ($past(i_hwdata[2:1], 2)
      == 2'b01) && o_ch2_static == $past(i_hwdata[2], 2)
      && o_ch2_static_level == &$past(i_hwdata[2:1], 2);
   endproperty
   a_ch2_en: assert property (p_ch2_en) else $error("ch2 enable mode wrong");
   property p_ch3_drv; wr_q && addr_q == 32'h1c |-> ##2 o_ch3_driver_type ==
      ($past(i_hwdata[8], 2) ? {$past(i_hwdata[7], 2), ~$past(i_hwdata[7], 2)} : 2'd0);
   endproperty
   a_ch3_drv: assert property (p_ch3_drv) else $error("ch3 driver kind wrong");
   property p_cfg4; wr_q && addr_q == 32'h24 |-> ##2
      o_ch4_fractional_enable == $past(i_hwdata[9], 2)
      && o_ch4_single_ended_slew == $past(i_hwdata[8], 2) && o_ch4_source_select ==
      (&$past(i_hwdata[14:13], 2) ? 2'd0 : $past(i_hwdata[14:13], 2)); endproperty
   a_cfg4: assert property (p_cfg4) else $error("ch4 mux, slew or enable wrong");
   property p_side; wr_q && addr_q == 32'h24 |-> ##2
      o_ch4_negative_side_enable == ($past(i_hwdata[7], 2) & $past(i_hwdata[6], 2));
   endproperty
   a_side: assert property (p_side) else $error("negative side without positive");
   property p_bypass; o_ch4_prescale_bypass |-> o_ch4_prescale_ratio == 2'd1
      && !o_ch4_fractional_enable; endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not honoured");
   property p_pre3; wr_q && addr_q == 32'h24 && i_hwdata[9] && i_hwdata[12:10] == 3'b001 |->
      ##2 o_ch4_prescale_ratio == 2'd3; endproperty
   a_pre3: assert property (p_pre3) else $error("prescale code 001 not three");
   property p_frac; wr_q && addr_q == 32'h2c |-> ##2
      o_ch4_fraction_word[15:0] == $past(i_hwdata[15:0], 2); endproperty
   a_frac: assert property (p_frac) else $error("fraction low word wrong");
   property p_unmapped; rd_q && addr_q >= 32'h34 |-> o_hrdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   c_cfg4: cover property (wr_q && addr_q == 32'h24);
   c_unmapped: cover property (rd_q && addr_q == 32'h34);
   c_both_sides: cover property (o_ch4_negative_side_enable);
endmodule
bind occ_output_config occ_output_config_chk #(.DIV_W(DIV_W), .FRAC_W(FRAC_W)) i_chk (
   .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
   .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
   .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
   .o_ch2_active(o_ch2_active), .o_ch2_static(o_ch2_static),
   .o_ch2_static_level(o_ch2_static_level), .o_ch3_driver_type(o_ch3_driver_type),
   .o_ch2_ch3_divide_ratio(o_ch2_ch3_divide_ratio), .o_ch4_source_select(o_ch4_source_select),
   .o_ch4_prescale_ratio(o_ch4_prescale_ratio), .o_ch4_prescale_bypass(o_ch4_prescale_bypass),
   .o_ch4_fractional_enable(o_ch4_fractional_enable),
   .o_ch4_single_ended_slew(o_ch4_single_ended_slew),
   .o_ch4_positive_side_enable(o_ch4_positive_side_enable),
   .o_ch4_negative_side_enable(o_ch4_negative_side_enable),
   .o_ch4_fraction_word(o_ch4_fraction_word));

// file: verif/tb_top.sv
// Self-checking testbench for the output channel config block
`timescale 1ns/100ps
module tb_top;
   reg         clk, rst_n, hsel, hwrite;
   reg  [31:0] haddr, hwdata, rd;
   reg  [1:0]  htrans;
   reg  [2:0]  hsize;
   reg  [51:0] r;
   reg  [51:0] rows [0:13];
   integer     errors, n_tests, i, j, k;
   wire [31:0] hrdata;
   wire        hready, hresp, a2, s2, l2, a3, s3, l3, sup23, byp, fen, slew, pos, neg;
   wire        a4, s4, l4, sup4;
   wire [1:0]  d2, d3, d4, src, pre;
   wire [8:0]  ratio;
   wire [19:0] frac;
   // Observed outputs packed per register, for table comparison
   wire [10:0] v23 = {d3, a3, s3, l3, d2, a2, s2, l2, sup23};
   wire [15:0] v4  = {1'b0, src, pre, byp, fen, slew, pos, neg, d4, a4, s4, l4, sup4};

   occ_output_config i_dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
      .o_hresp(hresp), .o_ch2_driver_type(d2), .o_ch2_active(a2), .o_ch2_static(s2),
      .o_ch2_static_level(l2), .o_ch3_driver_type(d3), .o_ch3_active(a3), .o_ch3_static(s3),
      .o_ch3_static_level(l3), .o_ch2_ch3_supply_level(sup23), .o_ch2_ch3_divide_ratio(ratio),
      .o_ch4_source_select(src), .o_ch4_prescale_ratio(pre), .o_ch4_prescale_bypass(byp),
      .o_ch4_fractional_enable(fen), .o_ch4_single_ended_slew(slew),
      .o_ch4_positive_side_enable(pos), .o_ch4_negative_side_enable(neg),
      .o_ch4_driver_type(d4), .o_ch4_active(a4), .o_ch4_static(s4), .o_ch4_static_level(l4),
      .o_ch4_supply_level(sup4), .o_ch4_fraction_word(frac));

   // 25 MHz core clock
   always #20 clk = ~clk;

   function [15:0] obs(input [3:0] idx);
      case (idx)
         4'd7: obs = {5'h0, v23};
         4'd8: obs = {7'h0, ratio};
         4'd9: obs = v4;
         4'd10: obs = {12'h0, frac[19:16]};
         default: obs = frac[15:0];
      endcase
   endfunction

   task tally_and_finish;
      begin
         if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   task check(input [31:0] seen, input [31:0] want);
      begin
         n_tests = n_tests + 1;
         if (seen !== want) begin
            errors = errors + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
         end
      end
   endtask

   // Bounded wait for hready at the next rising edges; a hang ends the run
   task wait_rdy;
      begin
         k = 0;
         @(posedge clk);
         while (hready !== 1'b1 && k < 20) begin
            k = k + 1;
            @(posedge clk);
         end
         if (k == 20) begin
            check(hready, 32'h1);
            tally_and_finish;
         end
      end
   endtask

   // One single word transfer; entered and left just after a rising edge
   task xfer(input wr, input [3:0] idx, input [15:0] wd, output [31:0] q);
      begin
         hsel <= 1'b1;
         htrans <= 2'b10;
         hwrite <= wr;
         haddr <= {26'h0, idx, 2'b00};
         wait_rdy;
         hsel <= 1'b0;
         htrans <= 2'b00;
         hwdata <= {16'h0, wd};
         wait_rdy;
         q = hrdata;
      end
   endtask

   // Outputs follow one edge after the register; look mid-cycle
   task chk_obs(input [3:0] idx, input [15:0] want);
      begin
         @(posedge clk);
         @(negedge clk);
         check({16'h0, obs(idx)}, {16'h0, want});
         @(posedge clk);
      end
   endtask

   task chk_reset;
      begin
         for (j = 7; j < 12; j = j + 1) begin
            xfer(1'b0, j[3:0], 16'h0, rd);
            check(rd, 32'h0);
         end
         chk_obs(4'd7, 16'h0000);
         chk_obs(4'd8, 16'h0001);
         chk_obs(4'd9, 16'h0c00);
      end
   endtask

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'b00;
      hsize = 3'd2;
      errors = 0;
      n_tests = 0;
      // Rows: index, written, read back, decoded outputs
      rows[0] = 52'h7feb500b50115;
      rows[1] = 52'h701e001e004c0;
      rows[2] = 52'h7015e015e02a6;
      rows[3] = 52'h7000b000b0009;
      rows[4] = 52'h8ff0000000001;
      rows[5] = 52'h8abff00ff0100;
      rows[6] = 52'h8004100410042;
      rows[7] = 52'h982f302d312d9;
      rows[8] = 52'h9279e271e3b26;
      rows[9] = 52'h95e455e454a85;
      rows[10] = 52'h960c860c80cc0;
      rows[11] = 52'haf00a000a000a;
      rows[12] = 52'hb123412341234;
      rows[13] = 52'hdffff00001234;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      chk_reset;
      for (i = 0; i < 14; i = i + 1) begin
         r = rows[i];
         xfer(1'b1, r[51:48], r[47:32], rd);
         chk_obs(r[51:48], r[15:0]);
         xfer(1'b0, r[51:48], 16'h0, rd);
         check(rd, {16'h0, r[31:16]});
      end
      // Back to back writes: both channels clocking share one ratio
      xfer(1'b1, 4'd7, 16'h0022, rd);
      xfer(1'b1, 4'd8, 16'h0003, rd);
      chk_obs(4'd7, 16'h0108);
      chk_obs(4'd8, 16'h0004);
      // Reserved prescale code with the fractional divider on gives ratio one
      xfer(1'b1, 4'd9, 16'h0a00, rd);
      chk_obs(4'd9, 16'h0a00);
      // Status shows the last channel 4 write: reserved code, then refused side
      xfer(1'b0, 4'd12, 16'h0, rd);
      check(rd, 32'h1);
      xfer(1'b1, 4'd9, 16'h0080, rd);
      xfer(1'b0, 4'd12, 16'h0, rd);
      check(rd, 32'h2);
      // Pipelined read in the data phase of a write to the same register
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= 1'b1;
      haddr <= 32'h00000020;
      wait_rdy;
      hwrite <= 1'b0;
      hwdata <= 32'h000000a5;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      wait_rdy;
      check(hrdata, 32'h000000a5);
      // Reset again in mid-run
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      chk_reset;
      tally_and_finish;
   end
endmodule
